// ### qde_divider.sv
`timescale 1ns/100ps
module qde_divider
	import qde_pkg::*;
#(
	parameter int DELAY_CYC = LATENCY_CYC
)(
	input  wire logic       clk_sys,       // system clock
	input  wire logic       nrst,          // sync reset, active low
	input  wire logic       step_in,       // interpolated count pulse
	input  wire logic       dir_in,        // 1 = forward
	input  wire logic       index_in,      // interpolated index
	input  wire logic [7:0] divider_config_switch, // switch bits
	input  wire logic [3:0] wire_break,    // sin+,sin-,cos+,cos- break
	input  wire logic [3:0] low_amplitude, // per line low amplitude
	input  wire logic       overspeed,     // input too fast
	input  wire logic [1:0] ref_fault,     // reference pair faults
	input  wire logic       error_release, // external acknowledge
	output logic            out_a,         // quadrature channel a
	output logic            out_b,         // quadrature channel b
	output logic            out_index,     // index out
	output logic            error_led,     // error indicator
	output logic            error_out      // error output
);
	qde_cfg_if cfg_bus();
	qde_sync u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.din     (divider_config_switch),
		.cfg_o   (cfg_bus.src)
	);

	// ---------------------------------
	// fixed latency line
	// ---------------------------------
	logic [DELAY_CYC-1:0] dl_step, dl_dir, dl_idx;
	logic [DELAY_CYC-1:0] next_dl_step, next_dl_dir, next_dl_idx;
	always_comb begin
		next_dl_step = {dl_step[DELAY_CYC-2:0], step_in};
		next_dl_dir  = {dl_dir[DELAY_CYC-2:0], dir_in};
		next_dl_idx  = {dl_idx[DELAY_CYC-2:0], index_in};
	end
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			dl_step <= '0;
			dl_dir  <= '0;
			dl_idx  <= '0;
		end else begin
			dl_step <= next_dl_step;
			dl_dir  <= next_dl_dir;
			dl_idx  <= next_dl_idx;
		end
	end
	logic d_step, d_dir, d_idx;
	assign d_step = dl_step[DELAY_CYC-1];
	assign d_dir  = dl_dir[DELAY_CYC-1];
	assign d_idx  = dl_idx[DELAY_CYC-1];

	// only valid with the default line length
	chk_fixed_delay: assert property (@(posedge clk_sys) disable iff (!nrst)
		step_in |-> ##300 d_step)
		else $error("delay line latency wrong");

	// ---------------------------------
	// divider
	// ---------------------------------
	logic [7:0] cfg_live;
	logic [7:0] cfg;
	logic [7:0] next_cfg;
	logic [RATIO_W-1:0] ratio;
	logic [RATIO_W-1:0] acc;
	logic [RATIO_W-1:0] next_acc;
	qde_phase_t phase, next_phase;
	logic [DIV_CODE_W-1:0] code;
	assign cfg_live = cfg_bus.cfg;
	assign code = cfg[DIV_CODE_LSB +: DIV_CODE_W];
	// ratio = 2*(64 - code); all ones gives 2, zeros 128
	assign ratio = {7'd64 - {1'b0, code}, 1'b0};

	logic out_step;
	logic next_a, next_b, next_index;
	always_comb begin
		next_cfg   = cfg;
		next_acc   = acc;
		out_step   = 1'b0;
		// new setting taken only between pulses
		if (!d_step)
			next_cfg = cfg_live;
		if (d_step) begin
			if (cfg[BYPASS_BIT]) begin
				out_step = 1'b1;
				next_acc = '0;
			end else if (acc + 8'h01 >= ratio) begin
				out_step = 1'b1;
				next_acc = '0;
			end else begin
				next_acc = acc + 8'h01;
			end
		end
		next_phase = phase;
		// gray walk keeps quadrature and direction
		if (out_step)
			next_phase = d_dir ? qde_phase_t'(phase + 2'd1) : qde_phase_t'(phase - 2'd1);
		case (next_phase)
			QDE_S0:  begin next_a = 1'b0; next_b = 1'b0; end
			QDE_S1:  begin next_a = 1'b1; next_b = 1'b0; end
			QDE_S2:  begin next_a = 1'b1; next_b = 1'b1; end
			QDE_S3:  begin next_a = 1'b0; next_b = 1'b1; end
			default: begin next_a = 1'b0; next_b = 1'b0; end
		endcase
		next_index = d_idx;
	end

	// ---------------------------------
	// output stage
	// ---------------------------------
	// phase and pins load together, so the pair never glitches
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cfg       <= CFG_RESET;
			acc       <= '0;
			phase     <= QDE_S0;
			out_a     <= 1'b0;
			out_b     <= 1'b0;
			out_index <= 1'b0;
		end else begin
			cfg       <= next_cfg;
			acc       <= next_acc;
			phase     <= next_phase;
			out_a     <= next_a;
			out_b     <= next_b;
			out_index <= next_index;
		end
	end

	chk_bypass_step: assert property (@(posedge clk_sys) disable iff (!nrst)
		(d_step && cfg[BYPASS_BIT]) |=> (phase != $past(phase)))
		else $error("bypass step missing");
	chk_ratio_range: assert property (@(posedge clk_sys) disable iff (!nrst)
		ratio >= 8'h02 && ratio <= 8'h80 && !ratio[0])
		else $error("ratio out of range");
	chk_quad_gray: assert property (@(posedge clk_sys) disable iff (!nrst)
		!((out_a != $past(out_a)) && (out_b != $past(out_b))))
		else $error("both channels changed");
	// outputs may only move on a delayed step
	chk_out_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
		!d_step |=> ($stable(out_a) && $stable(out_b)))
		else $error("output moved without step");
	chk_cfg_stable: assert property (@(posedge clk_sys) disable iff (!nrst)
		d_step |=> cfg == $past(cfg))
		else $error("config changed during pulse");
	chk_index_pass: assert property (@(posedge clk_sys) disable iff (!nrst)
		out_index == $past(d_idx))
		else $error("index not passed through");

	// ---------------------------------
	// error supervisor
	// ---------------------------------
	logic fault, err, next_err;
	assign fault = (|wire_break) | (|low_amplitude) | overspeed;
	always_comb begin
		if (cfg[LATCH_MODE_BIT])
			next_err = fault;
		// static mode, set wins over release
		else if (fault)
			next_err = 1'b1;
		else if (error_release)
			next_err = 1'b0;
		else
			next_err = err;
	end

	// both pins load one next value, so they never differ
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			err       <= 1'b0;
			error_led <= 1'b0;
			error_out <= 1'b0;
		end else begin
			err       <= next_err;
			error_led <= next_err;
			error_out <= next_err;
		end
	end

	chk_err_common: assert property (@(posedge clk_sys) disable iff (!nrst) error_led == error_out)
		else $error("error outputs differ");
	chk_fault_sets: assert property (@(posedge clk_sys) disable iff (!nrst) fault |=> error_out)
		else $error("fault did not raise error");
	// reference faults alone must leave the error low
	chk_ref_ignored: assert property (@(posedge clk_sys) disable iff (!nrst)
		(ref_fault != 2'h0 && !fault && !err) |=> !error_out)
		else $error("error from reference pair");
	chk_static_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		(err && !cfg[LATCH_MODE_BIT] && !error_release) |=> err)
		else $error("static error dropped without release");
	chk_release_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!cfg[LATCH_MODE_BIT] && !fault && error_release) |=> !err)
		else $error("release did not clear error");
	chk_auto_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		(cfg[LATCH_MODE_BIT] && !fault) |=> !err)
		else $error("auto error not cleared");
endmodule

// ### qde_pkg.sv
package qde_pkg;
	// divider switch layout
	localparam int DIV_CODE_LSB   = 0;
	localparam int DIV_CODE_W     = 6;
	localparam int LATCH_MODE_BIT = 6;
	localparam int BYPASS_BIT     = 7;
	localparam int CFG_W          = 8;
	localparam logic [7:0] CFG_RESET = 8'h80;
	// pipeline latency
	localparam int CLK_PERIOD_NS  = 10;
	localparam int LATENCY_NS     = 3000;
	localparam int LATENCY_CYC    = LATENCY_NS / CLK_PERIOD_NS;
	localparam int RATIO_W        = 8;
	typedef enum logic [1:0] {QDE_S0, QDE_S1, QDE_S2, QDE_S3} qde_phase_t;
endpackage

// ### qde_cfg_if.sv
`timescale 1ns/100ps
interface qde_cfg_if;
	logic [7:0] cfg;
	modport src (output cfg);
	modport dst (input cfg);
endinterface

// ### qde_sync.sv
`timescale 1ns/100ps
module qde_sync
	import qde_pkg::*;
(
	input  wire logic       clk_sys, // system clock
	input  wire logic       nrst,    // sync reset, active low
	input  wire logic [7:0] din,     // raw switch bits
	qde_cfg_if.src          cfg_o    // synchronised switch bits
);
	logic [7:0] stage1;
	logic [7:0] stage2;
	logic [7:0] next_stage1;
	logic [7:0] next_stage2;

	always_comb begin
		next_stage1 = din;
		next_stage2 = stage1;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			stage1 <= CFG_RESET;
			stage2 <= CFG_RESET;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end

	assign cfg_o.cfg = stage2;
endmodule

// ### qde_enc_model.sv
`timescale 1ns/100ps
module qde_enc_model
	import qde_pkg::*;
(
	input  wire logic clk_sys,   // clock
	input  wire logic out_a,     // channel a
	input  wire logic out_b,     // channel b
	input  wire logic out_index, // index
	input  wire logic error_out, // error
	output logic      step_in,   // step
	output logic      dir_in,    // direction
	output int        count,     // position
	output logic      idx_seen   // index seen
);
	logic [1:0] ph = 2'h0;
	logic [1:0] dph;
	assign dph = {out_b, out_a ^ out_b} - ph;
	initial begin
		step_in = 1'b0;
		dir_in = 1'b1;
		count = 0;
		idx_seen = 1'b0;
	end
	task automatic move(input int n, input logic fwd);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			step_in <= 1'b1;
			dir_in <= fwd;
			@(posedge clk_sys);
			step_in <= 1'b0;
		end
	endtask
	always @(posedge clk_sys) begin
		if (out_index)
			idx_seen <= 1'b1;
		if (!error_out && dph == 2'h1)
			count <= count + 1;
		else if (!error_out && dph == 2'h3)
			count <= count - 1;
		ph <= {out_b, out_a ^ out_b};
	end
endmodule

// ### quadrature_divider_error_monitor_tb.sv
`timescale 1ns/100ps
module quadrature_divider_error_monitor_tb;
	import qde_pkg::*;
	localparam int DLY = LATENCY_CYC;
	logic clk_sys = 1'b0, nrst = 1'b0, index_in = 1'b0, overspeed = 1'b0, error_release = 1'b0;
	logic [7:0] sw = 8'h80;
	logic [3:0] wire_break = 4'h0, low_amplitude = 4'h0;
	logic [1:0] ref_fault = 2'h0;
	logic step_in, dir_in, out_a, out_b, out_index, error_led, error_out, idx_seen;
	int count, c0, error_cnt = 0, tests_run = 0, cyc = 0;
	always #5 clk_sys = ~clk_sys;
	qde_divider #(.DELAY_CYC(DLY)) uut (.clk_sys(clk_sys), .nrst(nrst), .step_in(step_in),
		.dir_in(dir_in), .index_in(index_in), .divider_config_switch(sw), .wire_break(wire_break),
		.low_amplitude(low_amplitude), .overspeed(overspeed), .ref_fault(ref_fault),
		.error_release(error_release), .out_a(out_a), .out_b(out_b), .out_index(out_index),
		.error_led(error_led), .error_out(error_out));
	qde_enc_model enc (.clk_sys(clk_sys), .out_a(out_a), .out_b(out_b), .out_index(out_index),
		.error_out(error_out), .step_in(step_in), .dir_in(dir_in), .count(count), .idx_seen(idx_seen));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic set_sw(input logic [7:0] v);
		@(posedge clk_sys);
		sw <= v;
		wait_cyc(6);
	endtask
	task automatic t_bypass();
		set_sw(8'h80);
		c0 = count;
		enc.move(1, 1'b1);
		wait_cyc(DLY + 1);
		check("early", count - c0, 0);
		wait_cyc(1);
		check("one step", count - c0, 1);
		enc.move(5, 1'b0);
		wait_cyc(DLY + 3);
		check("reverse", count - c0, 32'hfffffffc);
		check("no index", idx_seen, 0);
		index_in <= 1'b1;
		wait_cyc(1);
		index_in <= 1'b0;
		wait_cyc(DLY + 3);
		check("index", idx_seen, 1);
	endtask
	task automatic t_div(input logic [5:0] code);
		set_sw({2'b00, code});
		c0 = count;
		enc.move(4 * (64 - code), 1'b1);
		wait_cyc(DLY + 3);
		check("divided", count - c0, 2);
	endtask
	task automatic t_err(input int i, input logic autom);
		@(posedge clk_sys);
		{overspeed, low_amplitude, wire_break} <= 9'h1 << i;
		wait_cyc(2);
		check("led", error_led, 1);
		check("out", error_out, 1);
		{overspeed, low_amplitude, wire_break} <= 9'h0;
		wait_cyc(3);
		check("held", error_out, !autom);
		error_release <= 1'b1;
		wait_cyc(3);
		error_release <= 1'b0;
		check("cleared", error_out, 0);
	endtask
	task automatic t_ref();
		ref_fault <= 2'h3;
		wait_cyc(3);
		check("ref out", error_out, 0);
		check("ref led", error_led, 0);
		ref_fault <= 2'h0;
	endtask
	initial begin
		wait_cyc(3);
		nrst <= 1'b1;
		wait_cyc(1);
		check("reset err", error_out, 0);
		check("reset a", out_a, 0);
		t_bypass();
		t_div(6'h3f);
		t_div(6'h3e);
		t_div(6'h3d);
		t_div(6'h00);
		for (int m = 0; m < 2; m++) begin
			set_sw(m ? 8'hc0 : 8'h80);
			for (int i = 0; i < 9; i++)
				t_err(i, m[0]);
			t_ref();
		end
		print_verdict();
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
endmodule
